// ===== iu_ctl_defs.svh
// Purpose: constants for the integer-core control block
// Assumes: included by bare name
// Notes: codes, priorities and reset values
`ifndef IU_CTL_DEFS_SVH
`define IU_CTL_DEFS_SVH
`define SPACE_FLUSH_I 4'h5
`define SPACE_FLUSH_D 4'h6
`define SPACE_UNC_HI 4'h7
`define SPACE_UNC_MAX 4'h4
`define SPACE_CACHED_LO 4'h8
`define SPACE_CACHED_HI 4'hB
`define SPACE_ITAG 4'hC
`define SPACE_IDATA 4'hD
`define SPACE_DTAG 4'hE
`define SPACE_DDATA 4'hF
`define TT_RESET 8'h00
`define TT_WRITE_ERR 8'h2B
`define TT_FETCH_ERR 8'h01
`define TT_PRIV 8'h03
`define TT_ILLEGAL 8'h02
`define TT_FP_DIS 8'h04
`define TT_WIN_OVF 8'h05
`define TT_WIN_UNF 8'h06
`define TT_ALIGN 8'h07
`define TT_FP_EXC 8'h08
`define TT_DATA_ERR 8'h09
`define TT_TAG_OVF 8'h0A
`define TT_DIV_ZERO 8'h2A
`define TT_SOFT_BASE 8'h80
`define TT_IRQ_BASE 8'h10
`define PRI_RESET 5'h01
`define PRI_WRITE_ERR 5'h02
`define PRI_FETCH_ERR 5'h03
`define PRI_PRIV 5'h04
`define PRI_ILLEGAL 5'h05
`define PRI_FP_DIS 5'h06
`define PRI_WIN 5'h07
`define PRI_ALIGN 5'h08
`define PRI_FP_EXC 5'h09
`define PRI_DATA 5'h0A
`define PRI_SOFT 5'h0B
`define PRI_IRQ_TOP 5'h1A
`define PRI_NONE 5'h1F
`define PC_RESET 32'h0000_0000
`define NPC_RESET 32'h0000_0004
`define PC_STEP 32'h0000_0004
`define CACHE_CTL_RESET 32'h0000_0000
`define CANCEL_CYCLES 2'h2
`define IRQ_L13 4'hD
`define IRQ_L14 4'hE
`define PSR_TRAPS_EN_BIT 5
`define PSR_SUPER_BIT 7
`define APB_PC 12'h000
`define APB_NPC 12'h004
`define APB_PSW 12'h008
`define APB_CACHE 12'h00C
`define APB_TRAP 12'h010
`define APB_CP_STAT 12'h014
`define APB_CP_RES_LO 12'h018
`define APB_CP_RES_HI 12'h01C
`define APB_FP_CFG 12'h020
`define APB_CP_OPLO 12'h024
`define APB_CP_OPHI 12'h028
`endif

// ===== iu_ctl_pkg.sv
// Purpose: shared types for the integer-core control block
// Assumes: nothing
// Notes: records of the execution unit port
package iu_ctl_pkg;
  typedef enum logic [2:0] {
    SPACE_UNCACHED = 3'h0,
    SPACE_FLUSH_ICACHE = 3'h1,
    SPACE_FLUSH_DCACHE = 3'h2,
    SPACE_CACHED = 3'h3,
    SPACE_ICACHE_TAG = 3'h4,
    SPACE_ICACHE_DATA = 3'h5,
    SPACE_DCACHE_TAG = 3'h6,
    SPACE_DCACHE_DATA = 3'h7
  } space_kind_t;
  typedef struct packed {
    logic [63:0] first_operand;
    logic [63:0] second_operand;
    logic [9:0] opcode;
    logic start;
    logic load;
    logic cancel;
  } cp_to_unit_t;
  typedef struct packed {
    logic [63:0] result;
    logic [1:0] condition_flags;
    logic [5:0] exc;
    logic busy;
  } cp_from_unit_t;
  typedef struct packed {
    logic reset_req;
    logic write_err;
    logic fetch_err;
    logic priv_user;
    logic unimplemented_op;
    logic fp_disabled;
    logic win_save_bad;
    logic win_restore_bad;
    logic misaligned;
    logic fp_exc;
    logic data_err;
    logic tag_ovf;
    logic div_zero;
    logic trap_always_op;
    logic [6:0] soft_num;
    logic [3:0] irq_level;
  } trap_req_t;
  typedef enum logic [1:0] {
    CP_IDLE = 2'b00,
    CP_LOAD = 2'b01,
    CP_WAIT = 2'b10,
    CP_CANCEL = 2'b11
  } cp_state_t;
endpackage

// ===== trap_encoder.sv
// Purpose: picks the winning trap and its type code
// Assumes: requests valid in the cycle presented
// Notes: purely combinational
`timescale 1ns/1ps
`default_nettype none
`include "iu_ctl_defs.svh"
module trap_encoder (
  input wire iu_ctl_pkg::trap_req_t req,
  output logic take,
  output logic [7:0] tt,
  output logic [4:0] pri
);
  // irq priority: level 1 is 25, down to 12, 13 and 14 share 13
  wire [4:0] irq_pri;
  assign irq_pri = (req.irq_level >= `IRQ_L14) ? 5'(`PRI_IRQ_TOP + 5'h01 - 5'(req.irq_level)) :
                   5'(`PRI_IRQ_TOP - 5'(req.irq_level));
  // fixed priority chain, smallest value wins
  always_comb begin
    tt = 8'h00;
    pri = `PRI_NONE;
    if (req.reset_req) begin
      tt = `TT_RESET; pri = `PRI_RESET;
    end else if (req.write_err) begin
      tt = `TT_WRITE_ERR; pri = `PRI_WRITE_ERR;
    end else if (req.fetch_err) begin
      tt = `TT_FETCH_ERR; pri = `PRI_FETCH_ERR;
    end else if (req.priv_user) begin
      tt = `TT_PRIV; pri = `PRI_PRIV;
    end else if (req.unimplemented_op) begin
      tt = `TT_ILLEGAL; pri = `PRI_ILLEGAL;
    end else if (req.fp_disabled) begin
      tt = `TT_FP_DIS; pri = `PRI_FP_DIS;
    end else if (req.win_save_bad) begin
      tt = `TT_WIN_OVF; pri = `PRI_WIN;
    end else if (req.win_restore_bad) begin
      tt = `TT_WIN_UNF; pri = `PRI_WIN;
    end else if (req.misaligned) begin
      tt = `TT_ALIGN; pri = `PRI_ALIGN;
    end else if (req.fp_exc) begin
      tt = `TT_FP_EXC; pri = `PRI_FP_EXC;
    end else if (req.data_err) begin
      tt = `TT_DATA_ERR; pri = `PRI_DATA;
    end else if (req.tag_ovf) begin
      tt = `TT_TAG_OVF; pri = `PRI_DATA;
    end else if (req.div_zero) begin
      tt = `TT_DIV_ZERO; pri = `PRI_DATA;
    end else if (req.trap_always_op) begin
      tt = `TT_SOFT_BASE | {1'b0, req.soft_num}; pri = `PRI_SOFT;
    end else if (req.irq_level != 4'h0) begin
      tt = `TT_IRQ_BASE | {4'h0, req.irq_level}; pri = irq_pri;
    end
  end
  assign take = (pri != `PRI_NONE);
endmodule
`default_nettype wire

// ===== iu_trap_asi_coproc_port.sv
// Purpose: integer-core control: space decode, traps, reset state, co-processor port
// Assumes: one clock, synchronous reset, APB for software view
// Notes: outputs all registered
//
// Local design decisions: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "iu_ctl_defs.svh"
module iu_trap_asi_coproc_port (
  // clock and reset
  input wire logic CLK,
  input wire logic RST,
  // apb slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // memory access space decode
  input wire logic ACC_VALID,
  input wire logic ACC_READ,
  input wire logic [7:0] ACC_SPACE,
  input wire logic CACHE_HIT,
  output iu_ctl_pkg::space_kind_t SPACE_KIND,
  output logic CACHE_UPDATE,
  output logic FLUSH_ICACHE,
  output logic FLUSH_DCACHE,
  // trap requests and result
  input wire iu_ctl_pkg::trap_req_t TRAP_REQ,
  output logic TRAP_TAKE,
  output logic [7:0] TRAP_TYPE,
  // fetch address
  output logic [31:0] FETCH_ADDR,
  // co-processor issue side
  input wire logic CP_ISSUE,
  input wire logic [31:0] CP_INSTR,
  input wire logic CP_DEP,
  input wire logic [63:0] CP_FIRST,
  input wire logic [63:0] CP_SECOND,
  input wire logic IU_TRAP_ABORT,
  input wire logic FP_INSTR,
  input wire logic FP_STORE_QUEUE,
  input wire logic [31:0] NEXT_FETCH,
  input wire logic ADVANCE,
  output logic CP_ACCEPT,
  output logic STALL,
  output logic QUEUE_NOT_EMPTY_FLAG,
  output logic FP_QUEUE_TRAP,
  // execution unit port
  output iu_ctl_pkg::cp_to_unit_t CP_OUT,
  input wire iu_ctl_pkg::cp_from_unit_t CP_IN
);
  // architectural state
  logic [31:0] pc_reg, pc_next;
  logic [31:0] next_program_counter_reg, npc_next;
  logic [31:0] processor_status_word_reg, psw_next;
  logic [31:0] cache_control_word_reg, ccw_next;
  logic fp_integrated_reg, fp_integrated_next;
  logic [7:0] last_tt_reg;
  iu_ctl_pkg::cp_state_t cp_state_reg, cp_state_next;
  logic [1:0] cancel_cnt_reg, cancel_cnt_next;
  logic [63:0] first_hold_reg, second_hold_reg;
  logic apb_write, apb_read;
  logic [31:0] rd_mux;
  logic rd_hit;

  // space decode function, high nibble ignored
  function automatic iu_ctl_pkg::space_kind_t decode_space(input logic [3:0] s);
    if (s <= `SPACE_UNC_MAX || s == `SPACE_UNC_HI) decode_space = iu_ctl_pkg::SPACE_UNCACHED;
    else if (s == `SPACE_FLUSH_I) decode_space = iu_ctl_pkg::SPACE_FLUSH_ICACHE;
    else if (s == `SPACE_FLUSH_D) decode_space = iu_ctl_pkg::SPACE_FLUSH_DCACHE;
    else if (s >= `SPACE_CACHED_LO && s <= `SPACE_CACHED_HI) decode_space = iu_ctl_pkg::SPACE_CACHED;
    else if (s == `SPACE_ITAG) decode_space = iu_ctl_pkg::SPACE_ICACHE_TAG;
    else if (s == `SPACE_IDATA) decode_space = iu_ctl_pkg::SPACE_ICACHE_DATA;
    else if (s == `SPACE_DTAG) decode_space = iu_ctl_pkg::SPACE_DCACHE_TAG;
    else decode_space = iu_ctl_pkg::SPACE_DCACHE_DATA;
  endfunction

  // space decode wires
  iu_ctl_pkg::space_kind_t kind_w;
  assign kind_w = decode_space(ACC_SPACE[3:0]);
  wire upd_w = ACC_VALID && ACC_READ && CACHE_HIT &&
               (kind_w == iu_ctl_pkg::SPACE_UNCACHED);
  wire fli_w = ACC_VALID && (kind_w == iu_ctl_pkg::SPACE_FLUSH_ICACHE);
  wire fld_w = ACC_VALID && (kind_w == iu_ctl_pkg::SPACE_FLUSH_DCACHE);

  // trap selection
  logic take_w;
  logic [7:0] tt_w;
  logic [4:0] pri_w;
  trap_encoder u_enc (
    .req(TRAP_REQ),
    .take(take_w),
    .tt(tt_w),
    .pri(pri_w)
  );

  // apb strobes; zero wait state
  assign apb_write = PSEL && PENABLE && PWRITE;
  assign apb_read = PSEL && !PENABLE && !PWRITE;

  // co-processor control
  wire [9:0] opcode_w = {CP_INSTR[19], CP_INSTR[13:5]};
  wire can_start = CP_ISSUE && !CP_DEP && !IU_TRAP_ABORT &&
                   (cp_state_reg != iu_ctl_pkg::CP_CANCEL);
  wire unit_pending = (cp_state_reg == iu_ctl_pkg::CP_LOAD) ||
                      (cp_state_reg == iu_ctl_pkg::CP_WAIT) || CP_IN.busy;
  wire fp_stall = FP_INSTR && (fp_integrated_reg ? 1'b1 : (CP_DEP && unit_pending));
  wire cp_stall = CP_ISSUE && CP_DEP && unit_pending;

  always_comb begin
    cp_state_next = cp_state_reg;
    cancel_cnt_next = cancel_cnt_reg;
    case (cp_state_reg)
      iu_ctl_pkg::CP_IDLE: begin
        if (can_start) cp_state_next = iu_ctl_pkg::CP_LOAD;
      end
      iu_ctl_pkg::CP_LOAD: begin
        if (IU_TRAP_ABORT) begin
          cp_state_next = iu_ctl_pkg::CP_CANCEL;
          cancel_cnt_next = `CANCEL_CYCLES;
        end else if (can_start) cp_state_next = iu_ctl_pkg::CP_LOAD;
        else cp_state_next = iu_ctl_pkg::CP_WAIT;
      end
      iu_ctl_pkg::CP_WAIT: begin
        if (IU_TRAP_ABORT && CP_IN.busy) begin
          cp_state_next = iu_ctl_pkg::CP_CANCEL;
          cancel_cnt_next = `CANCEL_CYCLES;
        end else if (can_start) cp_state_next = iu_ctl_pkg::CP_LOAD;
        else if (!CP_IN.busy) cp_state_next = iu_ctl_pkg::CP_IDLE;
      end
      iu_ctl_pkg::CP_CANCEL: begin
        cancel_cnt_next = cancel_cnt_reg - 2'h1;
        if (cancel_cnt_reg == 2'h1) cp_state_next = iu_ctl_pkg::CP_IDLE;
      end
      default: cp_state_next = iu_ctl_pkg::CP_IDLE;
    endcase
  end

  // pc and register updates
  always_comb begin
    pc_next = pc_reg;
    npc_next = next_program_counter_reg;
    psw_next = processor_status_word_reg;
    ccw_next = cache_control_word_reg;
    fp_integrated_next = fp_integrated_reg;
    if (ADVANCE && !STALL) begin
      pc_next = next_program_counter_reg;
      npc_next = NEXT_FETCH;
    end
    if (apb_write) begin
      case (PADDR)
        `APB_PC: pc_next = PWDATA;
        `APB_NPC: npc_next = PWDATA;
        `APB_PSW: psw_next = PWDATA;
        `APB_CACHE: ccw_next = PWDATA;
        `APB_FP_CFG: fp_integrated_next = PWDATA[0];
        default: ;
      endcase
    end
  end

  // register read mux
  always_comb begin
    rd_hit = 1'b1;
    case (PADDR)
      `APB_PC: rd_mux = pc_reg;
      `APB_NPC: rd_mux = next_program_counter_reg;
      `APB_PSW: rd_mux = processor_status_word_reg;
      `APB_CACHE: rd_mux = cache_control_word_reg;
      `APB_TRAP: rd_mux = {24'h00_0000, last_tt_reg};
      `APB_CP_STAT: rd_mux = {22'h00_0000, CP_IN.exc, CP_IN.condition_flags,
                              CP_IN.busy, 1'b0};
      `APB_CP_RES_LO: rd_mux = CP_IN.result[31:0];
      `APB_CP_RES_HI: rd_mux = CP_IN.result[63:32];
      `APB_FP_CFG: rd_mux = {31'h0000_0000, fp_integrated_reg};
      default: begin
        rd_mux = 32'h0000_0000;
        rd_hit = 1'b0;
      end
    endcase
  end

  // main state registers
  always_ff @(posedge CLK) begin
    if (RST) begin
      pc_reg <= `PC_RESET;
      next_program_counter_reg <= `NPC_RESET;
      processor_status_word_reg <= 32'h0000_0000 | (32'h1 << `PSR_SUPER_BIT);
      cache_control_word_reg <= `CACHE_CTL_RESET;
      fp_integrated_reg <= 1'b0;
      cp_state_reg <= iu_ctl_pkg::CP_IDLE;
      cancel_cnt_reg <= 2'h0;
      last_tt_reg <= `TT_RESET;
    end else begin
      pc_reg <= pc_next;
      next_program_counter_reg <= npc_next;
      processor_status_word_reg <= psw_next;
      cache_control_word_reg <= ccw_next;
      fp_integrated_reg <= fp_integrated_next;
      cp_state_reg <= cp_state_next;
      cancel_cnt_reg <= cancel_cnt_next;
      if (take_w) last_tt_reg <= tt_w;
    end
  end

  // operand hold for the load cycle
  always_ff @(posedge CLK) begin
    if (can_start) begin
      first_hold_reg <= CP_FIRST;
      second_hold_reg <= CP_SECOND;
    end
  end

  // registered outputs
  always_ff @(posedge CLK) begin
    if (RST) begin
      SPACE_KIND <= iu_ctl_pkg::SPACE_UNCACHED;
      CACHE_UPDATE <= 1'b0;
      FLUSH_ICACHE <= 1'b0;
      FLUSH_DCACHE <= 1'b0;
      TRAP_TAKE <= 1'b0;
      TRAP_TYPE <= `TT_RESET;
      FETCH_ADDR <= `PC_RESET;
      CP_ACCEPT <= 1'b0;
      STALL <= 1'b0;
      QUEUE_NOT_EMPTY_FLAG <= 1'b0;
      FP_QUEUE_TRAP <= 1'b0;
      CP_OUT <= '0;
      PRDATA <= 32'h0000_0000;
      PREADY <= 1'b0;
      PSLVERR <= 1'b0;
    end else begin
      SPACE_KIND <= kind_w;
      CACHE_UPDATE <= upd_w;
      FLUSH_ICACHE <= fli_w;
      FLUSH_DCACHE <= fld_w;
      TRAP_TAKE <= take_w;
      TRAP_TYPE <= tt_w;
      FETCH_ADDR <= pc_next;
      CP_ACCEPT <= can_start;
      STALL <= fp_stall || cp_stall;
      QUEUE_NOT_EMPTY_FLAG <= 1'b0;
      FP_QUEUE_TRAP <= fp_integrated_reg && FP_STORE_QUEUE;
      CP_OUT.start <= can_start;
      CP_OUT.opcode <= can_start ? opcode_w : CP_OUT.opcode;
      CP_OUT.load <= (cp_state_reg == iu_ctl_pkg::CP_LOAD);
      CP_OUT.first_operand <= first_hold_reg;
      CP_OUT.second_operand <= second_hold_reg;
      CP_OUT.cancel <= (cp_state_next == iu_ctl_pkg::CP_CANCEL);
      PREADY <= apb_read || (PSEL && !PENABLE && PWRITE);
      PSLVERR <= PSEL && !PENABLE && !rd_hit;
      PRDATA <= apb_read ? rd_mux : PRDATA;
    end
  end

  // checks
  cancel_two_a: assert property (@(posedge CLK) disable iff (RST)
    $rose(CP_OUT.cancel) |=> CP_OUT.cancel ##1 !CP_OUT.cancel)
    else $error("cancel strobe not two cycles");
  load_after_start_a: assert property (@(posedge CLK) disable iff (RST)
    CP_OUT.start |=> CP_OUT.load || CP_OUT.cancel || $past(IU_TRAP_ABORT))
    else $error("load missing after start");
  opcode_form_a: assert property (@(posedge CLK) disable iff (RST)
    can_start |=> CP_OUT.opcode == {$past(CP_INSTR[19]), $past(CP_INSTR[13:5])})
    else $error("opcode wrongly formed");
  space_high_a: assert property (@(posedge CLK) disable iff (RST)
    ACC_SPACE[3:0] == `SPACE_FLUSH_D |=> SPACE_KIND == iu_ctl_pkg::SPACE_FLUSH_DCACHE)
    else $error("space decode wrong");
  uncached_upd_a: assert property (@(posedge CLK) disable iff (RST)
    (ACC_VALID && ACC_READ && CACHE_HIT && ACC_SPACE[3:0] == `SPACE_UNC_HI) |=> CACHE_UPDATE)
    else $error("uncached hit did not update");
  reset_trap_a: assert property (@(posedge CLK) disable iff (RST)
    TRAP_REQ.reset_req |=> TRAP_TAKE && TRAP_TYPE == `TT_RESET)
    else $error("reset trap lost");
  qne_zero_a: assert property (@(posedge CLK) disable iff (RST)
    !QUEUE_NOT_EMPTY_FLAG)
    else $error("queue flag set");
  fp_stall_a: assert property (@(posedge CLK) disable iff (RST)
    (fp_integrated_reg && FP_INSTR) |=> STALL)
    else $error("integrated float did not stall");
  reset_pc_a: assert property (@(posedge CLK)
    $fell(RST) |-> pc_reg == `PC_RESET && next_program_counter_reg == `NPC_RESET)
    else $error("reset pc values wrong");
  start_each_cycle_a: assert property (@(posedge CLK) disable iff (RST)
    can_start |=> CP_OUT.start)
    else $error("start refused");
  // trap priority, space map, float attachment and co-processor checks
  irq_pri_a: assert property (@(posedge CLK) disable iff (RST)
    (take_w && tt_w == (`TT_IRQ_BASE | 8'h0F)) |-> pri_w == `PRI_SOFT + 5'h01)
    else $error("level 15 priority wrong");
  load_follows_a: assert property (@(posedge CLK) disable iff (RST)
    CP_OUT.load |-> $past(CP_OUT.start))
    else $error("load without start");
  flush_inst_a: assert property (@(posedge CLK) disable iff (RST)
    (ACC_VALID && ACC_SPACE[3:0] == `SPACE_FLUSH_I) |=> FLUSH_ICACHE)
    else $error("instruction flush missed");
  cached_space_a: assert property (@(posedge CLK) disable iff (RST)
    (ACC_SPACE[3:0] >= `SPACE_CACHED_LO && ACC_SPACE[3:0] <= `SPACE_CACHED_HI) |=>
    SPACE_KIND == iu_ctl_pkg::SPACE_CACHED)
    else $error("cached space decode wrong");
  cached_noupd_a: assert property (@(posedge CLK) disable iff (RST)
    (ACC_SPACE[3:0] >= `SPACE_CACHED_LO) |=> !CACHE_UPDATE)
    else $error("cache update outside uncached space");
  par_float_a: assert property (@(posedge CLK) disable iff (RST)
    (!fp_integrated_reg && !CP_DEP) |=> !STALL)
    else $error("parallel float stalled without dependency");
  cancel_cause_a: assert property (@(posedge CLK) disable iff (RST)
    $rose(CP_OUT.cancel) |-> $past(IU_TRAP_ABORT))
    else $error("cancel without abort");
  cp_start_c: cover property (@(posedge CLK) CP_OUT.start ##1 CP_OUT.start);
  cp_cancel_c: cover property (@(posedge CLK) $rose(CP_OUT.cancel));
  irq_c: cover property (@(posedge CLK) TRAP_TAKE && TRAP_TYPE == 8'h1F);
  flush_c: cover property (@(posedge CLK) FLUSH_ICACHE);
  par_float_c: cover property (@(posedge CLK) FP_INSTR && !fp_integrated_reg);
endmodule
`default_nettype wire

// ===== cp_unit_model.sv
// Purpose: behavioural co-processor execution unit
// Assumes: opcode comes with start, operands with load one cycle later
// Notes: slow gives a five-cycle job, else two
`timescale 1ns/1ps
`default_nettype none
module cp_unit_model (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // job length select
  input wire logic slow,
  // unit port
  input wire iu_ctl_pkg::cp_to_unit_t to_unit,
  output iu_ctl_pkg::cp_from_unit_t from_unit
);
  logic [63:0] a_reg;
  logic [63:0] b_reg;
  logic [9:0] op_reg;
  logic [2:0] cnt_reg;
  // start arms, load latches operands when no start comes in the same cycle, the count runs down to the result
  always_ff @(posedge clk) begin
    if (rst || to_unit.cancel) begin
      from_unit <= '0;
      cnt_reg <= 3'h0;
    end else if (to_unit.start) begin
      op_reg <= to_unit.opcode;
      from_unit.busy <= 1'h1;
      from_unit.result <= ~from_unit.result; // stale lines invert once at each start
      cnt_reg <= slow ? 3'h5 : 3'h2;
    end else begin
      if (to_unit.load) begin
        a_reg <= to_unit.first_operand;
        b_reg <= to_unit.second_operand;
      end
      if (cnt_reg != 3'h0) cnt_reg <= cnt_reg - 3'h1;
      if (cnt_reg == 3'h1) begin
        from_unit.busy <= 1'h0;
        from_unit.result <= a_reg + b_reg;
        from_unit.condition_flags <= op_reg[7:6];
        from_unit.exc <= op_reg[5:0];
      end
    end
  end
endmodule
`default_nettype wire

// ===== test_iu_trap_asi_coproc_port.sv
// Purpose: self-checking bench for the integer-core control block
// Assumes: outputs are sampled at the rising edge, inputs change by NBA on it
// Notes: xorshift stimulus from a fixed seed
`timescale 1ns/1ps
`default_nettype none
`include "iu_ctl_defs.svh"
module test_iu_trap_asi_coproc_port;
  logic clk = 1'h0, rst = 1'h1, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, cp_instr = 32'h0, fetch_addr, seed = 32'hB548A714;
  logic pready, pslverr, acc_valid = 1'h0, acc_read = 1'h0, cache_hit = 1'h0;
  logic [7:0] acc_space = 8'h00, trap_type;
  logic cache_update, flush_i, flush_d, trap_take, cp_issue = 1'h0, cp_dep = 1'h0;
  logic [63:0] cp_first = 64'h0, cp_second = 64'h0;
  logic abort = 1'h0, fp_instr = 1'h0, fp_sq = 1'h0, slow = 1'h0, advance = 1'h0;
  logic [31:0] next_fetch = 32'h0;
  logic cp_accept, stall, queue_not_empty_flag, fp_trap;
  iu_ctl_pkg::space_kind_t space_kind;
  iu_ctl_pkg::trap_req_t trap_req = '0;
  iu_ctl_pkg::cp_to_unit_t to_unit;
  iu_ctl_pkg::cp_from_unit_t from_unit;
  int err_count = 0, samples_checked = 0;
  // clock
  always #20 clk = ~clk;
  iu_trap_asi_coproc_port u_iu_trap_asi_coproc_port (
    .CLK(clk), .RST(rst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .ACC_VALID(acc_valid), .ACC_READ(acc_read), .ACC_SPACE(acc_space),
    .CACHE_HIT(cache_hit), .SPACE_KIND(space_kind), .CACHE_UPDATE(cache_update),
    .FLUSH_ICACHE(flush_i), .FLUSH_DCACHE(flush_d), .TRAP_REQ(trap_req),
    .TRAP_TAKE(trap_take), .TRAP_TYPE(trap_type), .FETCH_ADDR(fetch_addr),
    .CP_ISSUE(cp_issue), .CP_INSTR(cp_instr), .CP_DEP(cp_dep), .CP_FIRST(cp_first),
    .CP_SECOND(cp_second), .IU_TRAP_ABORT(abort), .FP_INSTR(fp_instr),
    .FP_STORE_QUEUE(fp_sq), .NEXT_FETCH(next_fetch), .ADVANCE(advance), .CP_ACCEPT(cp_accept),
    .STALL(stall), .QUEUE_NOT_EMPTY_FLAG(queue_not_empty_flag), .FP_QUEUE_TRAP(fp_trap),
    .CP_OUT(to_unit), .CP_IN(from_unit)
  );
  cp_unit_model u_cp_unit_model (
    .clk(clk), .rst(rst), .slow(slow), .to_unit(to_unit), .from_unit(from_unit)
  );
  // xorshift source
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // expected decode of the low nibble
  function automatic iu_ctl_pkg::space_kind_t kind_of(input logic [3:0] s);
    case (s)
      4'h5: return iu_ctl_pkg::SPACE_FLUSH_ICACHE;
      4'h6: return iu_ctl_pkg::SPACE_FLUSH_DCACHE;
      4'h8, 4'h9, 4'hA, 4'hB: return iu_ctl_pkg::SPACE_CACHED;
      4'hC: return iu_ctl_pkg::SPACE_ICACHE_TAG;
      4'hD: return iu_ctl_pkg::SPACE_ICACHE_DATA;
      4'hE: return iu_ctl_pkg::SPACE_DCACHE_TAG;
      4'hF: return iu_ctl_pkg::SPACE_DCACHE_DATA;
      default: return iu_ctl_pkg::SPACE_UNCACHED;
    endcase
  endfunction
  // expected {take, type}, walked in priority order
  function automatic logic [8:0] trap_of(input iu_ctl_pkg::trap_req_t q);
    if (q.reset_req) return 9'h100;
    if (q.write_err) return 9'h12B;
    if (q.fetch_err) return 9'h101;
    if (q.priv_user) return 9'h103;
    if (q.unimplemented_op) return 9'h102;
    if (q.fp_disabled) return 9'h104;
    if (q.win_save_bad) return 9'h105;
    if (q.win_restore_bad) return 9'h106;
    if (q.misaligned) return 9'h107;
    if (q.fp_exc) return 9'h108;
    if (q.data_err) return 9'h109;
    if (q.tag_ovf) return 9'h10A;
    if (q.div_zero) return 9'h12A;
    if (q.trap_always_op) return {2'h3, q.soft_num};
    if (q.irq_level != 4'h0) return {5'h11, q.irq_level};
    return 9'h000;
  endfunction
  task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  // one apb transfer, held until pready is sampled high
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
      output logic [31:0] q, output logic err);
    @(posedge clk);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'h1;
    do begin
      @(posedge clk);
    end while (pready !== 1'h1);
    q = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task automatic rdchk(input string w, input logic [11:0] a, input logic [31:0] e);
    logic [31:0] q;
    logic err;
    apb(1'h0, a, 32'h0, q, err);
    chk(w, e, q);
  endtask
  // issue n instructions on consecutive edges and watch the unit port
  task automatic cp_burst(input int n, input logic sl);
    logic [31:0] ins [0:2];
    logic [63:0] a;
    logic [63:0] b;
    a = {rnd(), rnd()};
    b = {rnd(), rnd()};
    for (int j = 0; j < 3; j++) ins[j] = rnd();
    cp_first <= a;
    cp_second <= b;
    slow <= sl;
    cp_issue <= 1'h1;
    cp_instr <= ins[0];
    for (int k = 1; k <= n + 2; k++) begin
      @(posedge clk);
      if (k <= n) cp_issue <= (k < n);
      cp_instr <= ins[k % 3];
      if (k >= 2 && k - 2 < n) begin
        chk("start", 1, to_unit.start);
        chk("opcode", {ins[k - 2][19], ins[k - 2][13:5]}, to_unit.opcode);
        chk("accept", 1, cp_accept);
      end
      if (k >= 3) begin
        chk("load", 1, to_unit.load);
        chk("first_op", a, to_unit.first_operand);
        chk("second_op", b, to_unit.second_operand);
      end
    end
    if (!sl) begin
      for (int w = 0; w < 20 && from_unit.busy !== 1'h0; w++) @(posedge clk);
      rdchk("res_lo", `APB_CP_RES_LO, a[31:0] + b[31:0]);
      rdchk("res_hi", `APB_CP_RES_HI, 32'((a + b) >> 32));
    end
  endtask
  task automatic conclude();
    if (err_count == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // watchdog
  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    conclude();
  end
  // main sequence
  initial begin
    logic [31:0] q, r, s;
    logic err;
    int c;
    iu_ctl_pkg::trap_req_t t;
    repeat (2) @(posedge clk);
    rst <= 1'h0;
    @(posedge clk);
    chk("fetch", 0, fetch_addr);
    rdchk("pc", `APB_PC, 32'h0);
    rdchk("npc", `APB_NPC, 32'h4);
    apb(1'h0, `APB_PSW, 32'h0, q, err);
    chk("status", 2'h2, {q[7], q[5]});
    rdchk("cache", `APB_CACHE, 32'h0);
    // one advance step moves the next pc into pc and takes a new next pc
    s = rnd();
    advance <= 1'h1;
    next_fetch <= s;
    @(posedge clk);
    advance <= 1'h0;
    @(posedge clk);
    chk("fetch_step", 32'h4, fetch_addr);
    rdchk("npc_step", `APB_NPC, s);
    apb(1'h0, 12'h100, 32'h0, q, err);
    chk("slverr", 1, err);
    // space decode, every low nibble under random high nibbles
    for (int i = 0; i < 48; i++) begin
      r = rnd();
      acc_valid <= 1'h1;
      acc_read <= r[8];
      cache_hit <= r[9];
      acc_space <= {r[7:4], 4'(i)};
      @(posedge clk);
      @(posedge clk);
      chk("space", kind_of(4'(i)), space_kind);
      chk("flush", {4'(i) == 4'h5, 4'(i) == 4'h6}, {flush_i, flush_d});
      chk("update", (kind_of(4'(i)) == 0) & r[8] & r[9], cache_update);
    end
    acc_valid <= 1'h0;
    // single traps, every interrupt level, then random mixes
    for (int i = 0; i < 90; i++) begin
      r = rnd();
      s = rnd();
      t = '0;
      t.soft_num = r[6:0];
      if (i < 14) t[24 - i] = 1'h1;
      else if (i < 29) t.irq_level = 4'(i - 13);
      else begin
        t[24:11] = r[31:18] & s[13:0] & s[27:14];
        t.irq_level = r[10:7];
        if (t.win_save_bad) t.win_restore_bad = 1'h0;
        if (t.data_err) t.tag_ovf = 1'h0;
        if (t.data_err || t.tag_ovf) t.div_zero = 1'h0;
      end
      trap_req <= t;
      @(posedge clk);
      @(posedge clk);
      chk("trap", trap_of(t),
          {trap_take, trap_take ? trap_type : 8'h00});
    end
    trap_req <= '0;
    @(posedge clk);
    // co-processor: single and back to back, fast jobs only
    for (int i = 0; i < 6; i++) cp_burst(1 + (i % 2), 1'h0);
    // slow job keeps the unit busy: a dependent issue stalls, then a trap aborts it
    cp_burst(1, 1'h1);
    cp_dep <= 1'h1;
    cp_issue <= 1'h1;
    @(posedge clk);
    cp_issue <= 1'h0;
    cp_dep <= 1'h0;
    @(posedge clk);
    chk("dep_start", 0, to_unit.start);
    chk("dep_stall", 1, stall);
    abort <= 1'h1;
    @(posedge clk);
    abort <= 1'h0;
    c = 0;
    repeat (8) begin
      @(posedge clk);
      c += to_unit.cancel;
    end
    chk("cancel", 2, c);
    // integrated then parallel float attachment
    for (int m = 1; m >= 0; m--) begin
      apb(1'h1, `APB_FP_CFG, 32'(m), q, err);
      fp_instr <= 1'h1;
      fp_sq <= 1'h1;
      @(posedge clk);
      @(posedge clk);
      chk("stall", m, stall);
      chk("qne", 0, queue_not_empty_flag);
      chk("sq_trap", m, fp_trap);
      fp_instr <= 1'h0;
      fp_sq <= 1'h0;
      repeat (2) @(posedge clk);
    end
    conclude();
  end
endmodule
`default_nettype wire
